// ===== logic/byte_fifo.sv
/*
  First-in first-out store in flip-flops with a synchronous flush.
  Assumes one clock and a synchronous active-low reset; a write while
  full and a read while empty are ignored.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 9,
  parameter int AW = 10
) (
  input logic clk_i,
  input logic rst_n_i,
  input logic clr_i,
  input logic wr_valid_i,
  input logic [W-1:0] wr_data_i,
  output logic wr_ready_o,
  output logic rd_valid_o,
  output logic [W-1:0] rd_data_o,
  input logic rd_ready_i
);
  localparam int DEPTH = 1 << AW;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
  } fifo_s;

  fifo_s st;
  fifo_s next_st;
  logic wr;
  logic rd;

  // flush drops the contents but leaves the storage as it is
  always_comb begin
    next_st = st;
    wr = wr_valid_i && (st.cnt != FULL);
    rd = rd_ready_i && (st.cnt != '0);
    if (clr_i) begin
      next_st.wptr = '0;
      next_st.rptr = '0;
      next_st.cnt = '0;
    end else begin
      if (wr) begin
        next_st.mem[st.wptr] = wr_data_i;
        next_st.wptr = st.wptr + 1'b1;
      end
      if (rd) begin
        next_st.rptr = st.rptr + 1'b1;
      end
      unique case ({wr, rd})
        2'b10: next_st.cnt = st.cnt + 1'b1;
        2'b01: next_st.cnt = st.cnt - 1'b1;
        default: next_st.cnt = st.cnt;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wr_ready_o = (st.cnt != FULL);
  assign rd_valid_o = (st.cnt != '0);
  assign rd_data_o = st.mem[st.rptr];
endmodule

// ===== logic/gpib_dev_pkg.sv
/*
  Types shared by the instrument bus port: byte type and the one-hot
  states of the acceptor and source handshakes.
  Assumes nothing of its surroundings.
*/
package gpib_dev_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    AH_IDLE  = 3'b001,
    AH_READY = 3'b010,
    AH_WAIT  = 3'b100
  } ah_state_e;
  typedef enum logic [3:0] {
    SH_IDLE   = 4'b0001,
    SH_SETTLE = 4'b0010,
    SH_XFER   = 4'b0100,
    SH_DONE   = 4'b1000
  } sh_state_e;
endpackage

// ===== logic/gpib_dev_port.sv
/*
  Instrument side of a parallel handshaked instrument bus: talker,
  listener, service request, remote/local, device clear and trigger,
  with an input buffer toward the parser and an output queue of replies.
  Assumes bus pins already synchronous to clk_i, open-drain wires
  resolved outside, and an active-low electrical level on every line.
*/
// Overview of operation
// - Device functions only, never a controller
// - Full source handshake when talking
// - Full acceptor handshake when listening or commanded
// - Talker, talk-only; own listen address unaddresses talk
// - Listener, no listen-only; own talk unaddresses listen
// - Full service request via SRQ
// - Full remote/local following REN and commands
// - No parallel poll response at all
// - Full device clear, universal and addressed
// - Group trigger acts when listen addressed
// - Data bytes only while ATN high
// - Bus commands only while ATN low
// - Program bytes in, responses out only
// - Received bytes held in 1 Kbyte FIFO
// - Reply byte kept until controller reads it
// - Universal clear reinitialises message exchange
// - Selected clear acts only when listen addressed
// - Interface clear returns talker, listener and handshakes idle; remote and service request kept
`timescale 1ns/1ps
`include "gpib_dev_regs.svh"
module gpib_dev_port (
  input logic clk_i,
  input logic rst_n_i,
  input logic [4:0] my_addr_i,
  input logic talk_only_i,
  input logic rtl_i,
  input logic rsv_i,
  input gpib_dev_pkg::byte_t stb_i,
  input gpib_dev_pkg::byte_t dio_n_i,
  output gpib_dev_pkg::byte_t dio_n_o,
  output gpib_dev_pkg::byte_t dio_oe_o,
  input logic dav_n_i,
  output logic dav_n_o,
  output logic dav_oe_o,
  input logic nrfd_n_i,
  output logic nrfd_n_o,
  output logic nrfd_oe_o,
  input logic ndac_n_i,
  output logic ndac_n_o,
  output logic ndac_oe_o,
  input logic eoi_n_i,
  output logic eoi_n_o,
  output logic eoi_oe_o,
  input logic atn_n_i,
  input logic ifc_n_i,
  input logic ren_n_i,
  output logic srq_n_o,
  output logic srq_oe_o,
  output gpib_dev_pkg::byte_t rx_data_o,
  output logic rx_end_o,
  output logic rx_valid_o,
  input logic rx_ready_i,
  input gpib_dev_pkg::byte_t tx_data_i,
  input logic tx_end_i,
  input logic tx_valid_i,
  output logic tx_ready_o,
  output logic trigger_o,
  output logic clear_o,
  output logic remote_o,
  output logic lockout_o,
  output logic talk_o,
  output logic listen_o
);
  import gpib_dev_pkg::*;

  typedef struct packed {
    ah_state_e ah;
    sh_state_e sh;
    logic talk;
    logic listen;
    logic spe;
    logic rqs;
    logic rsv_q;
    logic remote;
    logic lockout;
    logic poll_xfer;
    logic [7:0] settle;
    byte_t dio_oe;
    logic dav_oe;
    logic nrfd_oe;
    logic ndac_oe;
    logic eoi_oe;
    logic [8:0] rx;
    logic rx_push;
    logic tx_pop;
    logic trigger;
    logic clear;
  } dev_s;

  localparam dev_s RST_S = '{ah: AH_IDLE, sh: SH_IDLE, default: '0};

  dev_s st;
  dev_s next_st;
  logic in_ready;
  logic [8:0] out_data;
  logic out_valid;
  logic [6:0] cmd;
  logic part;
  logic rdy;
  logic take;
  logic talker;
  logic abort;
  logic polled;
  byte_t tx_byte;

  function automatic logic addr_hit(input logic [6:0] c,
                                    input logic [1:0] g,
                                    input logic [4:0] a);
    return (c[6:5] == g) && (c[4:0] == a);
  endfunction

  // handshake qualifiers; the bus is active low so bytes are inverted
  always_comb begin
    cmd = ~dio_n_i[6:0];
    part = !atn_n_i || st.listen;
    rdy = !atn_n_i || (in_ready && !st.rx_push);
    take = (st.ah == AH_READY) && !st.nrfd_oe && rdy && part &&
           !dav_n_i && ifc_n_i;
    talker = st.talk || talk_only_i;
    // commands on the bus preempt any talker mid-byte
    abort = !atn_n_i || !talker || st.clear;
    tx_byte = st.spe ? {stb_i[7], st.rqs, stb_i[5:0]} : out_data[7:0];
  end

  // one next-state process for both handshakes and all addressing
  always_comb begin
    next_st = st;
    polled = 1'b0;
    next_st.rx_push = 1'b0;
    next_st.tx_pop = 1'b0;
    next_st.trigger = 1'b0;
    next_st.clear = 1'b0;
    next_st.rsv_q = rsv_i;

    // acceptor handshake
    unique case (st.ah)
      AH_IDLE: begin
        if (part) begin
          next_st.ah = AH_READY;
          next_st.ndac_oe = 1'b1;
          next_st.nrfd_oe = !rdy;
        end
      end
      AH_READY: begin
        if (!part) begin
          next_st.ah = AH_IDLE;
          next_st.ndac_oe = 1'b0;
          next_st.nrfd_oe = 1'b0;
        end else if (take) begin
          next_st.ah = AH_WAIT;
          next_st.nrfd_oe = 1'b1;
          next_st.ndac_oe = 1'b0;
          if (atn_n_i) begin
            // data byte, eoi kept beside it for the parser
            next_st.rx = {!eoi_n_i, ~dio_n_i};
            next_st.rx_push = 1'b1;
          end else begin
            // interface commands
            if (addr_hit(cmd, `GRP_LISTEN, my_addr_i)) begin
              next_st.listen = 1'b1;
              next_st.talk = 1'b0;
              next_st.remote = !ren_n_i || st.remote;
            end else if (addr_hit(cmd, `GRP_TALK, my_addr_i)) begin
              next_st.talk = 1'b1;
              next_st.listen = 1'b0;
            end else if (cmd[6:5] == `GRP_LISTEN &&
                         cmd[4:0] == `ADDR_UN) begin
              next_st.listen = 1'b0;
            end else if (cmd[6:5] == `GRP_TALK) begin
              // untalk or another talker takes the bus
              next_st.talk = 1'b0;
            end
            unique case (cmd)
              `CMD_DCL: next_st.clear = 1'b1;
              `CMD_SDC: next_st.clear = st.listen;
              `CMD_GET: next_st.trigger = st.listen;
              `CMD_GTL: begin
                if (st.listen) begin
                  next_st.remote = 1'b0;
                end
              end
              `CMD_LLO: next_st.lockout = 1'b1;
              `CMD_SPE: next_st.spe = 1'b1;
              `CMD_SPD: next_st.spe = 1'b0;
              // poll configure is accepted and dropped
              `CMD_PPC, `CMD_PPU: next_st.spe = st.spe;
              default: next_st.spe = st.spe;
            endcase
          end
        end else begin
          next_st.nrfd_oe = !rdy;
        end
      end
      AH_WAIT: begin
        if (!part) begin
          next_st.ah = AH_IDLE;
          next_st.ndac_oe = 1'b0;
          next_st.nrfd_oe = 1'b0;
        end else if (dav_n_i) begin
          next_st.ah = AH_READY;
          next_st.ndac_oe = 1'b1;
          next_st.nrfd_oe = !rdy;
        end
      end
    endcase

    // source handshake, replies or the polled status byte
    unique case (st.sh)
      SH_IDLE: begin
        if (atn_n_i && talker && !st.clear &&
            ((st.spe && st.talk) || out_valid)) begin
          next_st.sh = SH_SETTLE;
          next_st.poll_xfer = st.spe && st.talk;
          next_st.dio_oe = tx_byte;
          next_st.eoi_oe = !(st.spe && st.talk) && out_data[8];
          next_st.settle = 8'(`SETTLE_CYC);
        end
      end
      SH_SETTLE: begin
        if (abort) begin
          next_st.sh = SH_IDLE;
          next_st.dio_oe = '0;
          next_st.eoi_oe = 1'b0;
        end else if (st.settle != 8'h00) begin
          next_st.settle = st.settle - 8'h01;
        end else if (nrfd_n_i) begin
          next_st.sh = SH_XFER;
          next_st.dav_oe = 1'b1;
        end
      end
      SH_XFER: begin
        if (abort) begin
          // byte stays queued, the read never completed
          next_st.sh = SH_IDLE;
          next_st.dav_oe = 1'b0;
          next_st.dio_oe = '0;
          next_st.eoi_oe = 1'b0;
        end else if (ndac_n_i) begin
          next_st.sh = SH_DONE;
          next_st.dav_oe = 1'b0;
          polled = st.poll_xfer;
          next_st.tx_pop = !st.poll_xfer;
        end
      end
      SH_DONE: begin
        next_st.sh = SH_IDLE;
        next_st.dio_oe = '0;
        next_st.eoi_oe = 1'b0;
      end
    endcase

    // request service; a new request wins over the poll clearing it
    next_st.rqs = (rsv_i && !st.rsv_q) ||
                  (st.rqs && rsv_i && !polled);

    // remote/local: REN released forces local and lifts lockout
    if (ren_n_i) begin
      next_st.remote = 1'b0;
      next_st.lockout = 1'b0;
    end else if (rtl_i && !st.lockout) begin
      next_st.remote = 1'b0;
    end

    // interface clear from the system controller, never sent here
    if (!ifc_n_i) begin
      next_st.talk = 1'b0;
      next_st.listen = 1'b0;
      next_st.spe = 1'b0;
      next_st.ah = AH_IDLE;
      next_st.sh = SH_IDLE;
      next_st.nrfd_oe = 1'b0;
      next_st.ndac_oe = 1'b0;
      next_st.dav_oe = 1'b0;
      next_st.dio_oe = '0;
      next_st.eoi_oe = 1'b0;
      next_st.tx_pop = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= RST_S;
    end else begin
      st <= next_st;
    end
  end

  // clear flushes both buffers but no instrument settings
  byte_fifo #(.W(9), .AW(`IN_AW)) u_in_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(st.clear),
    .wr_valid_i(st.rx_push),
    .wr_data_i(st.rx),
    .wr_ready_o(in_ready),
    .rd_valid_o(rx_valid_o),
    .rd_data_o({rx_end_o, rx_data_o}),
    .rd_ready_i(rx_ready_i)
  );

  byte_fifo #(.W(9), .AW(`OUT_AW)) u_out_queue (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(st.clear),
    .wr_valid_i(tx_valid_i),
    .wr_data_i({tx_end_i, tx_data_i}),
    .wr_ready_o(tx_ready_o),
    .rd_valid_o(out_valid),
    .rd_data_o(out_data),
    .rd_ready_i(st.tx_pop)
  );

  // open-drain pins only ever pull low
  assign dio_n_o = '0;
  assign dav_n_o = 1'b0;
  assign nrfd_n_o = 1'b0;
  assign ndac_n_o = 1'b0;
  assign eoi_n_o = 1'b0;
  assign srq_n_o = 1'b0;
  assign dio_oe_o = st.dio_oe;
  assign dav_oe_o = st.dav_oe;
  assign nrfd_oe_o = st.nrfd_oe;
  assign ndac_oe_o = st.ndac_oe;
  assign eoi_oe_o = st.eoi_oe;
  assign srq_oe_o = st.rqs;
  assign trigger_o = st.trigger;
  assign clear_o = st.clear;
  assign remote_o = st.remote;
  assign lockout_o = st.lockout;
  assign talk_o = st.talk;
  assign listen_o = st.listen;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_take_cmd;
    take && !atn_n_i;
  endsequence

  property p_dav_after_ready;
    $rose(st.dav_oe) |-> $past(nrfd_n_i) && $past(st.sh == SH_SETTLE);
  endproperty
  a_dav_after_ready: assert property (p_dav_after_ready)
    else $error("data valid raised without ready for data");

  property p_dav_drop;
    st.sh == SH_XFER && ndac_n_i && !abort && ifc_n_i |=>
      !st.dav_oe && st.sh == SH_DONE ##1 st.dio_oe == '0;
  endproperty
  a_dav_drop: assert property (p_dav_drop)
    else $error("source did not release after data accepted");

  property p_accept;
    take |=> st.nrfd_oe && !st.ndac_oe && st.ah == AH_WAIT;
  endproperty
  a_accept: assert property (p_accept)
    else $error("acceptor did not answer a valid byte");

  property p_hold_full;
    st.ah == AH_READY && atn_n_i && st.listen && !in_ready &&
      ifc_n_i |=> st.nrfd_oe;
  endproperty
  a_hold_full: assert property (p_hold_full)
    else $error("ready for data while input buffer full");

  property p_mla;
    s_take_cmd ##0 addr_hit(cmd, `GRP_LISTEN, my_addr_i) |=>
      st.listen && !st.talk;
  endproperty
  a_mla: assert property (p_mla)
    else $error("own listen address left talker addressed");

  property p_mta;
    s_take_cmd ##0 addr_hit(cmd, `GRP_TALK, my_addr_i) |=>
      st.talk && !st.listen;
  endproperty
  a_mta: assert property (p_mta)
    else $error("own talk address left listener addressed");

  property p_srq;
    $rose(rsv_i) |=> srq_oe_o;
  endproperty
  a_srq: assert property (p_srq)
    else $error("service request not raised");

  property p_ren;
    ren_n_i |=> !remote_o && !lockout_o;
  endproperty
  a_ren: assert property (p_ren)
    else $error("remote held with REN released");

  property p_dcl;
    s_take_cmd ##0 cmd == `CMD_DCL |=> clear_o ##1 !clear_o;
  endproperty
  a_dcl: assert property (p_dcl)
    else $error("universal clear not a one-cycle pulse");

  property p_sdc_unaddr;
    s_take_cmd ##0 cmd == `CMD_SDC && !st.listen |=> !clear_o;
  endproperty
  a_sdc_unaddr: assert property (p_sdc_unaddr)
    else $error("selected clear acted while not addressed");

  property p_get;
    s_take_cmd ##0 cmd == `CMD_GET && st.listen |=> trigger_o;
  endproperty
  a_get: assert property (p_get)
    else $error("trigger missing for addressed group trigger");

  property p_ifc;
    !ifc_n_i |=> !st.talk && !st.listen && st.ah == AH_IDLE &&
      !st.dav_oe;
  endproperty
  a_ifc: assert property (p_ifc)
    else $error("interface clear left a function active");

  property p_cmd_no_push;
    s_take_cmd |=> !st.rx_push;
  endproperty
  a_cmd_no_push: assert property (p_cmd_no_push)
    else $error("command byte entered the input buffer");
endmodule

// ===== logic/gpib_dev_regs.svh
/*
  Constants of the bus-side instrument port: interface command codes,
  address groups, status byte layout, buffer sizes and the data settle
  time ahead of a source handshake.
  Assumes the includer compiles with a 250 MHz clock.
*/
`ifndef GPIB_DEV_REGS_SVH
`define GPIB_DEV_REGS_SVH

// universal and addressed commands, low seven bits of the bus byte
`define CMD_GTL 7'h01
`define CMD_SDC 7'h04
`define CMD_PPC 7'h05
`define CMD_GET 7'h08
`define CMD_LLO 7'h11
`define CMD_DCL 7'h14
`define CMD_PPU 7'h15
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19

// address groups in bits 6:5 and the unaddress code
`define GRP_LISTEN 2'h1
`define GRP_TALK 2'h2
`define ADDR_UN 5'h1f

// request-service bit in the polled status byte
`define STB_RQS 6

// buffer depths as address widths
`define IN_AW 10
`define OUT_AW 8

// data settle time before the data-valid strobe
`define CLK_PERIOD_NS 4
`define SETTLE_NS 500
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== verif/gpib_ctl_model.sv
/*
  Behavioural bus controller facing the instrument port: sends commands
  and data with a source handshake, reads replies as a listener.
  Assumes the bench resolves every open-drain line from all enables.
*/
`timescale 1ns/1ps
module gpib_ctl_model (
  input wire logic clk_i,
  input wire logic [7:0] dio_n_i,
  input wire logic dav_n_i,
  input wire logic nrfd_n_i,
  input wire logic ndac_n_i,
  input wire logic eoi_n_i,
  output logic [7:0] c_dio_oe_o,
  output logic c_dav_oe_o,
  output logic c_nrfd_oe_o,
  output logic c_ndac_oe_o,
  output logic c_eoi_oe_o,
  output logic atn_n_o,
  output logic ifc_n_o,
  output logic ren_n_o
);
  // released lines float high through the bus pull-ups
  initial begin
    c_dio_oe_o = 8'h00;
    {c_dav_oe_o, c_nrfd_oe_o, c_ndac_oe_o, c_eoi_oe_o} = 4'h0;
    {atn_n_o, ifc_n_o, ren_n_o} = 3'h7;
  end

  // attention, clear and remote enable come only from this side
  task automatic lines(input logic ren_n, input logic ifc_n);
    @(negedge clk_i);
    ren_n_o = ren_n;
    ifc_n_o = ifc_n;
  endtask

  // interface clear is held for about 100 us
  task automatic ifc_pulse();
    lines(ren_n_o, 1'b0);
    repeat (25000) @(negedge clk_i);
    ifc_n_o = 1'b1;
  endtask

  // source handshake; attention low marks a bus command
  task automatic put(input logic cmd, input logic [7:0] b, input logic e,
                     input int lim, output logic ok);
    int n;
    @(negedge clk_i);
    atn_n_o = ~cmd;
    c_nrfd_oe_o = 1'b0;
    c_ndac_oe_o = 1'b0;
    c_dio_oe_o = b;
    c_eoi_oe_o = e & ~cmd;
    for (n = 0; n < lim && nrfd_n_i !== 1'b1; n++) @(negedge clk_i);
    ok = 1'b0;
    if (nrfd_n_i === 1'b1) begin
      @(negedge clk_i); // data settles ahead of the strobe
      c_dav_oe_o = 1'b1;
      for (n = 0; n < 2000 && ndac_n_i !== 1'b1; n++) @(negedge clk_i);
      ok = ndac_n_i;
    end
    @(negedge clk_i);
    c_dav_oe_o = 1'b0;
    c_dio_oe_o = 8'h00;
    c_eoi_oe_o = 1'b0;
    @(negedge clk_i);
  endtask

  // acceptor handshake in data mode; slow stretches both halves
  task automatic get(input int slow, output logic [7:0] b, output logic e,
                     output logic ok);
    int n;
    @(negedge clk_i);
    atn_n_o = 1'b1;
    c_ndac_oe_o = 1'b1;
    c_nrfd_oe_o = 1'b1;
    repeat (slow + 1) @(negedge clk_i);
    c_nrfd_oe_o = 1'b0;
    for (n = 0; n < 2000 && dav_n_i !== 1'b0; n++) @(negedge clk_i);
    ok = ~dav_n_i;
    b = ~dio_n_i;
    e = ~eoi_n_i;
    c_nrfd_oe_o = 1'b1;
    repeat (slow + 1) @(negedge clk_i);
    c_ndac_oe_o = 1'b0;
    for (n = 0; n < 200 && dav_n_i !== 1'b1; n++) @(negedge clk_i);
    @(negedge clk_i);
    c_nrfd_oe_o = 1'b0;
  endtask
endmodule

// ===== verif/tb.sv
/*
  Self-checking bench of the instrument bus port against a behavioural
  controller; every scenario is a task of its own.
  Assumes the port's header constants and a 250 MHz clock.
*/
`timescale 1ns/1ps
`include "gpib_dev_regs.svh"
module tb;
  import gpib_dev_pkg::*;
  localparam logic [4:0] ADR = 5'h07;
  localparam byte_t MLA = {1'b0, `GRP_LISTEN, ADR};
  localparam byte_t MTA = {1'b0, `GRP_TALK, ADR};
  localparam byte_t UNL = {1'b0, `GRP_LISTEN, `ADDR_UN};
  byte_t dio_n_i, dio_oe_o, c_dio, rx_data_o, tx_data_i, stb_i, b;
  logic clk_i, rst_n_i, talk_only_i, rtl_i, rsv_i, rx_ready_i;
  logic dav_n_i, dav_oe_o, c_dav, nrfd_n_i, nrfd_oe_o, c_nrfd;
  logic ndac_n_i, ndac_oe_o, c_ndac, eoi_n_i, eoi_oe_o, c_eoi;
  logic atn_n_i, ifc_n_i, ren_n_i, srq_oe_o, rx_end_o, rx_valid_o;
  logic tx_end_i, tx_valid_i, tx_ready_o, trigger_o, clear_o;
  logic remote_o, lockout_o, talk_o, listen_o, e, ok;
  logic [1:0] atn_hist;
  int fails = 0;
  int n_checks = 0;
  int n_trig = 0;
  int n_clr = 0;

  // pull-up lines: low while any party enables its driver
  assign dio_n_i = ~(dio_oe_o | c_dio);
  assign dav_n_i = ~(dav_oe_o | c_dav);
  assign nrfd_n_i = ~(nrfd_oe_o | c_nrfd);
  assign ndac_n_i = ~(ndac_oe_o | c_ndac);
  assign eoi_n_i = ~(eoi_oe_o | c_eoi);

  gpib_dev_port dut (.clk_i, .rst_n_i, .my_addr_i(ADR), .talk_only_i,
    .rtl_i, .rsv_i, .stb_i, .dio_n_i, .dio_n_o(), .dio_oe_o, .dav_n_i,
    .dav_n_o(), .dav_oe_o, .nrfd_n_i, .nrfd_n_o(), .nrfd_oe_o, .ndac_n_i,
    .ndac_n_o(), .ndac_oe_o, .eoi_n_i, .eoi_n_o(), .eoi_oe_o, .atn_n_i,
    .ifc_n_i, .ren_n_i, .srq_n_o(), .srq_oe_o, .rx_data_o, .rx_end_o,
    .rx_valid_o, .rx_ready_i, .tx_data_i, .tx_end_i, .tx_valid_i,
    .tx_ready_o, .trigger_o, .clear_o, .remote_o, .lockout_o, .talk_o,
    .listen_o);

  gpib_ctl_model ctl (.clk_i, .dio_n_i, .dav_n_i, .nrfd_n_i, .ndac_n_i,
    .eoi_n_i, .c_dio_oe_o(c_dio), .c_dav_oe_o(c_dav), .c_nrfd_oe_o(c_nrfd),
    .c_ndac_oe_o(c_ndac), .c_eoi_oe_o(c_eoi), .atn_n_o(atn_n_i),
    .ifc_n_o(ifc_n_i), .ren_n_o(ren_n_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic err(input string m);
    fails++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk_bit(input logic g, input logic x, input string m);
    n_checks++;
    if (g !== x) err(m);
  endtask
  task automatic chk_byte(input byte_t g, input byte_t x, input string m);
    n_checks++;
    if (g !== x) err(m);
  endtask

  // pulse counters, and a watch on the data lines in command mode
  always @(posedge clk_i) begin
    atn_hist <= {atn_hist[0], atn_n_i};
    if (trigger_o === 1'b1) n_trig++;
    if (clear_o === 1'b1) n_clr++;
    if (atn_hist == 2'b00 && atn_n_i === 1'b0 && dio_oe_o !== 8'h00)
      err("data lines driven in command mode");
  end

  task automatic cmd(input byte_t c);
    ctl.put(1'b1, c, 1'b0, 2000, ok);
    if (ok !== 1'b1) err("command not accepted");
  endtask
  task automatic dat(input byte_t d, input logic x);
    ctl.put(1'b0, d, x, 2000, ok);
    if (ok !== 1'b1) err("data not accepted");
  endtask
  // head checked, then popped; caller lowers ready after the last one
  task automatic pop_chk(input byte_t x, input logic xe);
    chk_bit(rx_valid_o, 1'b1, "buffer empty");
    chk_byte(rx_data_o, x, "buffer data");
    chk_bit(rx_end_o, xe, "buffer end mark");
    rx_ready_i = 1'b1;
    @(negedge clk_i);
  endtask
  task automatic push(input byte_t d, input logic x);
    tx_data_i = d;
    tx_end_i = x;
    tx_valid_i = 1'b1;
    @(negedge clk_i);
  endtask
  task automatic rd(input int slow, input byte_t x, input logic xe);
    ctl.get(slow, b, e, ok);
    chk_bit(ok, 1'b1, "no reply");
    chk_byte(b, x, "reply data");
    chk_bit(e, xe, "reply end mark");
  endtask

  task automatic t_idle();
    chk_bit(nrfd_oe_o, 1'b0, "nrfd");
    chk_bit(dav_oe_o, 1'b0, "dav");
    chk_bit(srq_oe_o, 1'b0, "srq");
    chk_bit(tx_ready_o, 1'b1, "queue room");
    chk_bit(listen_o | talk_o, 1'b0, "addressed");
    $display("test idle done");
  endtask

  task automatic t_listen();
    ctl.put(1'b0, 8'h58, 1'b0, 50, ok);
    chk_bit(rx_valid_o, 1'b0, "taken unaddressed");
    ctl.lines(1'b0, 1'b1);
    cmd(MLA);
    chk_bit(listen_o, 1'b1, "listen");
    chk_bit(remote_o, 1'b1, "remote");
    cmd({1'b0, `CMD_PPC});
    cmd({1'b0, `CMD_PPU});
    chk_bit(listen_o, 1'b1, "poll command effect");
    dat(8'h41, 1'b0);
    dat(8'h42, 1'b1);
    pop_chk(8'h41, 1'b0);
    pop_chk(8'h42, 1'b1);
    rx_ready_i = 1'b0;
    chk_bit(rx_valid_o, 1'b0, "left over");
    $display("test listen done");
  endtask

  task automatic t_clear();
    dat(8'h43, 1'b0);
    n_clr = 0;
    n_trig = 0;
    cmd({1'b0, `CMD_SDC});
    chk_bit(n_clr == 1, 1'b1, "selected clear");
    chk_bit(rx_valid_o, 1'b0, "not flushed");
    dat(8'h44, 1'b0);
    cmd(UNL);
    cmd({1'b0, `CMD_SDC});
    cmd({1'b0, `CMD_GET});
    chk_bit(rx_valid_o, 1'b1, "unaddressed clear");
    chk_bit(n_trig == 0, 1'b1, "unaddressed trigger");
    cmd({1'b0, `CMD_DCL});
    chk_bit(n_clr == 2, 1'b1, "universal clear");
    chk_bit(rx_valid_o, 1'b0, "not flushed");
    cmd(MLA);
    cmd({1'b0, `CMD_GET});
    chk_bit(n_trig == 1, 1'b1, "trigger");
    $display("test clear done");
  endtask

  task automatic t_full();
    for (int i = 0; i < 1024; i++) dat(byte_t'(i), 1'b0);
    ctl.put(1'b0, 8'haa, 1'b0, 60, ok);
    chk_bit(ok, 1'b0, "taken while full");
    chk_bit(nrfd_oe_o, 1'b1, "no stall");
    pop_chk(8'h00, 1'b0);
    rx_ready_i = 1'b0;
    dat(8'haa, 1'b0);
    for (int i = 1; i < 1024; i++) pop_chk(byte_t'(i), 1'b0);
    pop_chk(8'haa, 1'b0);
    rx_ready_i = 1'b0;
    $display("test full done");
  endtask

  task automatic t_talk();
    push(8'h31, 1'b0);
    push(8'h0a, 1'b1);
    push(8'h77, 1'b0);
    tx_valid_i = 1'b0;
    cmd(MTA);
    chk_bit(talk_o, 1'b1, "talk");
    chk_bit(listen_o, 1'b0, "listen kept");
    rd(0, 8'h31, 1'b0);
    rd(30, 8'h0a, 1'b1);
    rd(400, 8'h77, 1'b0);
    cmd(MLA);
    chk_bit(talk_o, 1'b0, "talk kept");
    $display("test talk done");
  endtask

  task automatic t_srq();
    rsv_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk_bit(srq_oe_o, 1'b1, "service request");
    cmd({1'b0, `CMD_SPE});
    cmd(MTA);
    rd(0, 8'h45, 1'b0);
    chk_bit(srq_oe_o, 1'b0, "request after poll");
    cmd({1'b0, `CMD_SPD});
    rsv_i = 1'b0;
    cmd(MLA);
    $display("test srq done");
  endtask

  task automatic t_remote();
    cmd({1'b0, `CMD_GTL});
    chk_bit(remote_o, 1'b0, "go to local");
    cmd(MLA);
    rtl_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk_bit(remote_o, 1'b0, "panel local");
    rtl_i = 1'b0;
    cmd(MLA);
    cmd({1'b0, `CMD_LLO});
    chk_bit(lockout_o, 1'b1, "lockout");
    rtl_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk_bit(remote_o, 1'b1, "local under lockout");
    rtl_i = 1'b0;
    ctl.ifc_pulse();
    repeat (2) @(negedge clk_i);
    chk_bit(listen_o, 1'b0, "interface clear");
    chk_bit(remote_o, 1'b1, "remote lost");
    ctl.lines(1'b1, 1'b1);
    repeat (2) @(negedge clk_i);
    chk_bit(remote_o | lockout_o, 1'b0, "remote enable off");
    talk_only_i = 1'b1;
    push(8'h55, 1'b1);
    tx_valid_i = 1'b0;
    rd(0, 8'h55, 1'b1);
    talk_only_i = 1'b0;
    $display("test remote done");
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // about 33k cycles are expected; this allows 100k
  initial begin
    #400000;
    err("watchdog expired");
    conclude();
  end

  initial begin
    {rst_n_i, talk_only_i, rtl_i, rsv_i, rx_ready_i} = 5'h00;
    {tx_end_i, tx_valid_i} = 2'h0;
    tx_data_i = 8'h00;
    stb_i = 8'h05;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_idle();
    t_listen();
    t_clear();
    t_full();
    t_talk();
    t_srq();
    t_remote();
    conclude();
  end
endmodule
